/* logic/spi_slave_ram_port.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_slave_ram_port (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Shared pins, serial function
	input wire logic port_select_low_in,
	input wire logic serial_clock_in,
	input wire logic serial_in_pin_in,
	output logic serial_out_out,
	output logic serial_out_oe_n_out,
	output logic pins_to_port_out,
	// Processor bus
	input wire spi_port_pkg::mpu_bus_t mpu_in,
	output logic [7:0] mpu_rdata_out,
	output logic cmd_irq_out,
	// External data RAM master
	output spi_port_pkg::ram_req_t ram_out,
	input wire logic ram_ack_in,
	input wire logic [7:0] ram_rdata_in
);
	spi_port_pkg::pins_t pins_s;
	spi_port_pkg::phase_t phase_r;
	logic en_r;
	logic sck_d_r;
	logic sel_act_d_r;
	logic sel_act;
	logic rise;
	logic fall;
	logic end_evt;
	logic [7:0] rx_byte;
	logic done;
	logic [2:0] bit_cnt;
	logic sh_sdo;
	logic load;
	logic [7:0] load_byte;
	logic [7:0] first_byte_r;
	logic [7:0] cmd_cur_r;
	logic [7:0] cmd_r;
	logic [7:0] stat_r;
	logic [15:0] ptr_r;
	logic rd_dir_r;
	logic [2:0] tot_r;
	logic [2:0] data_cnt_r;
	logic wpar_r;
	logic rpar_r;
	logic nrdy_r;
	logic [7:0] rd_buf_r;
	logic buf_vld_r;
	logic issue;
	logic issue_we;
	logic [7:0] stat_nxt;

	pin_sync #(.W(3)) u_sync (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.async_in({port_select_low_in, serial_clock_in, serial_in_pin_in}),
		.rst_val_in(3'h7),
		.sync_out(pins_s)
	);

	// Disabled port looks permanently deselected
	assign sel_act = en_r && !pins_s.sel_n;
	assign rise = sel_act && pins_s.sck && !sck_d_r;
	assign fall = sel_act && !pins_s.sck && sck_d_r;
	assign end_evt = sel_act_d_r && !sel_act;

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			sck_d_r <= 1'b0;
			sel_act_d_r <= 1'b0;
		end else begin
			sck_d_r <= pins_s.sck;
			sel_act_d_r <= sel_act;
		end
	end

	always_comb begin
		load = 1'b0;
		load_byte = stat_r;
		if (done && phase_r == spi_port_pkg::PH_CMD) begin
			load = 1'b1;
		end else if (done && rd_dir_r && (phase_r == spi_port_pkg::PH_STAT || phase_r == spi_port_pkg::PH_DATA)) begin
			load = 1'b1;
			load_byte = rd_buf_r;
		end
	end

	byte_shifter u_shift (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.clear_in(!sel_act),
		.rise_in(rise),
		.fall_in(fall),
		.sdi_in(pins_s.sdi),
		.load_in(load),
		.load_byte_in(load_byte),
		.rx_byte_out(rx_byte),
		.done_out(done),
		.bit_cnt_out(bit_cnt),
		.sdo_out(sh_sdo)
	);

	// Byte phase sequence
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !sel_act) begin
			phase_r <= spi_port_pkg::PH_IDLE;
		end else if (done) begin
			unique case (phase_r)
				spi_port_pkg::PH_IDLE: phase_r <= spi_port_pkg::PH_ADDR_LO;
				spi_port_pkg::PH_ADDR_LO: phase_r <= spi_port_pkg::PH_CMD;
				spi_port_pkg::PH_CMD: phase_r <= spi_port_pkg::PH_STAT;
				spi_port_pkg::PH_STAT: phase_r <= spi_port_pkg::PH_DATA;
				spi_port_pkg::PH_DATA: phase_r <= spi_port_pkg::PH_DATA;
				default: phase_r <= spi_port_pkg::PH_IDLE;
			endcase
		end
	end

	// Captured fields and counters of the running transaction
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !sel_act) begin
			first_byte_r <= spi_port_pkg::BYTE_ZERO;
			cmd_cur_r <= spi_port_pkg::BYTE_ZERO;
			rd_dir_r <= 1'b0;
			tot_r <= 3'h0;
			data_cnt_r <= 3'h0;
		end else if (done) begin
			if (tot_r != spi_port_pkg::TOT_SAT)
				tot_r <= tot_r + 3'h1;
			if (phase_r == spi_port_pkg::PH_IDLE)
				first_byte_r <= rx_byte;
			if (phase_r == spi_port_pkg::PH_CMD) begin
				cmd_cur_r <= rx_byte;
				rd_dir_r <= rx_byte[spi_port_pkg::DIR_BIT];
			end
			if (phase_r == spi_port_pkg::PH_DATA)
				data_cnt_r <= data_cnt_r + 3'h1;
		end
	end

	// RAM access: read prefetch from the command byte on, write after each data byte
	assign issue = done && ((phase_r == spi_port_pkg::PH_CMD && rx_byte[spi_port_pkg::DIR_BIT])
		|| (rd_dir_r && phase_r == spi_port_pkg::PH_STAT)
		|| (phase_r == spi_port_pkg::PH_DATA));
	assign issue_we = (phase_r == spi_port_pkg::PH_DATA) && !rd_dir_r;

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ptr_r <= 16'h0000;
		end else if (done && phase_r == spi_port_pkg::PH_ADDR_LO) begin
			ptr_r <= {first_byte_r, rx_byte};
		end else if (issue && !ram_out.req) begin
			ptr_r <= ptr_r + spi_port_pkg::ADDR_STEP;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ram_out <= '0;
		end else if (issue && !ram_out.req) begin
			ram_out.req <= 1'b1;
			ram_out.we <= issue_we;
			ram_out.addr <= ptr_r;
			ram_out.wdata <= rx_byte;
		end else if (ram_ack_in) begin
			ram_out.req <= 1'b0;
		end
	end

	// A set on ack wins over the clear by a load in the same cycle
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !sel_act) begin
			rd_buf_r <= spi_port_pkg::BYTE_ZERO;
			buf_vld_r <= 1'b0;
		end else if (ram_ack_in && ram_out.req && !ram_out.we) begin
			rd_buf_r <= ram_rdata_in;
			buf_vld_r <= 1'b1;
		end else if (load && phase_r != spi_port_pkg::PH_CMD) begin
			buf_vld_r <= 1'b0;
		end
	end

	// Parity and not-ready accumulation; a busy RAM port drops the access
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !sel_act) begin
			wpar_r <= 1'b0;
			rpar_r <= 1'b0;
			nrdy_r <= 1'b0;
		end else begin
			if (done && (phase_r != spi_port_pkg::PH_STAT) && !(phase_r == spi_port_pkg::PH_DATA && rd_dir_r))
				wpar_r <= wpar_r ^ (^rx_byte);
			if (load && phase_r != spi_port_pkg::PH_CMD)
				rpar_r <= rpar_r ^ (^rd_buf_r);
			if ((issue && ram_out.req) || (load && phase_r != spi_port_pkg::PH_CMD && !buf_vld_r))
				nrdy_r <= 1'b1;
		end
	end

	always_comb begin
		stat_nxt = spi_port_pkg::BYTE_ZERO;
		stat_nxt[spi_port_pkg::ST_NRDY] = nrdy_r || (bit_cnt != 3'h0);
		stat_nxt[spi_port_pkg::ST_RPAR] = rpar_r;
		stat_nxt[spi_port_pkg::ST_WPAR] = wpar_r;
		stat_nxt[spi_port_pkg::ST_CNT_HI:spi_port_pkg::ST_CNT_LO] =
			(tot_r <= spi_port_pkg::TOT_MULTI) ? spi_port_pkg::CNT_SHORT : data_cnt_r;
	end

	// Status of the previous transaction, sampled at deselect
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			stat_r <= spi_port_pkg::STAT_RESET;
		end else if (end_evt && (tot_r != 3'h0 || bit_cnt != 3'h0)) begin
			stat_r <= stat_nxt;
		end
	end

	// Command register is never cleared by deselect
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			cmd_r <= spi_port_pkg::CMD_RESET;
			cmd_irq_out <= 1'b0;
		end else begin
			cmd_irq_out <= 1'b0;
			if (end_evt && tot_r == spi_port_pkg::TOT_ONE) begin
				cmd_r <= first_byte_r;
				cmd_irq_out <= 1'b1;
			end else if (end_evt && tot_r >= spi_port_pkg::TOT_MULTI
				&& cmd_cur_r != spi_port_pkg::CMD_RD_SILENT && cmd_cur_r != spi_port_pkg::CMD_WR_SILENT) begin
				cmd_r <= cmd_cur_r;
				cmd_irq_out <= 1'b1;
			end
		end
	end

	// Processor side: enable bit and read-back, one cycle read latency
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			en_r <= spi_port_pkg::EN_RESET;
		end else if (mpu_in.wr && !mpu_in.sfr && mpu_in.addr == spi_port_pkg::CFG_ADDR) begin
			en_r <= mpu_in.wdata[spi_port_pkg::EN_BIT];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			mpu_rdata_out <= spi_port_pkg::BYTE_ZERO;
		end else if (mpu_in.rd) begin
			mpu_rdata_out <= spi_port_pkg::BYTE_ZERO;
			if (mpu_in.sfr && mpu_in.addr[7:0] == spi_port_pkg::CMD_SFR_ADDR)
				mpu_rdata_out <= cmd_r;
			else if (!mpu_in.sfr && mpu_in.addr == spi_port_pkg::STAT_ADDR)
				mpu_rdata_out <= stat_r;
			else if (!mpu_in.sfr && mpu_in.addr == spi_port_pkg::CFG_ADDR)
				mpu_rdata_out[spi_port_pkg::EN_BIT] <= en_r;
		end
	end

	// Pin drivers; driven only in the status byte and in read data
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			serial_out_out <= 1'b0;
			serial_out_oe_n_out <= 1'b1;
			pins_to_port_out <= spi_port_pkg::EN_RESET;
		end else begin
			serial_out_out <= sh_sdo;
			serial_out_oe_n_out <= !(sel_act && (phase_r == spi_port_pkg::PH_STAT
				|| (phase_r == spi_port_pkg::PH_DATA && rd_dir_r)));
			pins_to_port_out <= en_r;
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence cmd_byte_end;
		phase_r == spi_port_pkg::PH_CMD && done;
	endsequence
	sequence stat_on_pin;
		##2 (serial_out_out == stat_r[7] && !serial_out_oe_n_out);
	endsequence

	out_float_a: assert property (!sel_act |=> serial_out_oe_n_out)
		else $error("serial output driven while deselected");
	stat_first_a: assert property (cmd_byte_end |-> stat_on_pin)
		else $error("status MSB not on pin after command byte");
	single_cmd_a: assert property (end_evt && tot_r == spi_port_pkg::TOT_ONE |=> cmd_irq_out && cmd_r == $past(first_byte_r))
		else $error("single byte did not update command and interrupt");
	silent_cmd_a: assert property (end_evt && tot_r >= spi_port_pkg::TOT_MULTI && (cmd_cur_r == spi_port_pkg::CMD_RD_SILENT
		|| cmd_cur_r == spi_port_pkg::CMD_WR_SILENT) |=> !cmd_irq_out && $stable(cmd_r))
		else $error("silent command raised interrupt or changed register");
	irq_pulse_a: assert property (cmd_irq_out |=> !cmd_irq_out)
		else $error("interrupt pulse longer than one cycle");
	addr_step_a: assert property (issue && !ram_out.req |=> ram_out.req && ram_out.addr == $past(ptr_r)
		&& ptr_r == $past(ptr_r) + spi_port_pkg::ADDR_STEP)
		else $error("RAM address not issued or not incremented");
	dir_bit_a: assert property (cmd_byte_end |=> rd_dir_r == $past(rx_byte[spi_port_pkg::DIR_BIT])
		&& phase_r == spi_port_pkg::PH_STAT)
		else $error("direction bit not taken from command MSB");
	partial_err_a: assert property (end_evt && bit_cnt != 3'h0 |=> stat_r[spi_port_pkg::ST_NRDY])
		else $error("partial byte not flagged in status");
	short_cnt_a: assert property (end_evt && tot_r != 3'h0 && tot_r <= spi_port_pkg::TOT_MULTI
		|=> stat_r[spi_port_pkg::ST_CNT_HI:spi_port_pkg::ST_CNT_LO] == spi_port_pkg::CNT_SHORT)
		else $error("short transaction count not 111");
	pin_release_a: assert property (!en_r |=> !pins_to_port_out ##1 !cmd_irq_out || !en_r)
		else $error("pins still claimed after disable");
endmodule
`default_nettype wire

/* logic/spi_port_pkg.sv */
// Contract
// - While select is high the port stays reset, output floats, clock and data ignored.
// - Transaction starts on first rising clock after select falls, ends when select rises.
// - Order: optional 16-bit address, 8-bit command, status byte out, then data bytes.
// - In multi-byte transactions the command MSB gives the data direction.
// - Command MSB set reads from the address onward; clear writes from the address onward.
// - On deselect after multi-byte, copy command and interrupt unless command is 0x80 or 0x00.
// - A single-byte transaction always updates the command register and interrupts.
// - RAM address increments after every data byte.
// - Status byte sent in each data transaction, also readable by the processor.
// - Not-ready service or a partial final byte is flagged as error in next status.
// - Status: bit7 not-ready, bit6 read parity, bit5 write parity, bits4:2 byte count.
// - A byte takes at least eight clocks, so RAM accesses stay slow enough.
// - The 16-bit address reaches the whole external data RAM space only.
// - After reset the shared pins default to the serial port.
// - Clearing the enable bit disables the port and releases the shared pins.
// - Select, clock, data in and data out use four shared segment pins.
`default_nettype none
package spi_port_pkg;
	localparam logic [7:0] CMD_SFR_ADDR = 8'hFD;
	localparam logic [15:0] STAT_ADDR = 16'h2708;
	localparam logic [15:0] CFG_ADDR = 16'h270C;
	localparam int EN_BIT = 4;
	localparam logic EN_RESET = 1'b1;
	localparam int DIR_BIT = 7;
	localparam logic [7:0] CMD_RD_SILENT = 8'h80;
	localparam logic [7:0] CMD_WR_SILENT = 8'h00;
	localparam int ST_NRDY = 7;
	localparam int ST_RPAR = 6;
	localparam int ST_WPAR = 5;
	localparam int ST_CNT_HI = 4;
	localparam int ST_CNT_LO = 2;
	localparam logic [2:0] CNT_SHORT = 3'h7;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] TOT_ONE = 3'h1;
	localparam logic [2:0] TOT_MULTI = 3'h3;
	localparam logic [2:0] TOT_SAT = 3'h4;
	localparam logic [15:0] ADDR_STEP = 16'h0001;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR_LO = 3'b001,
		PH_CMD = 3'b011,
		PH_STAT = 3'b010,
		PH_DATA = 3'b110
	} phase_t;

	typedef struct packed {
		logic sfr;
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mpu_bus_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ram_req_t;

	typedef struct packed {
		logic sel_n;
		logic sck;
		logic sdi;
	} pins_t;
endpackage
`default_nettype wire

/* logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Pins and synchronised copies
	input wire logic [W-1:0] async_in,
	input wire logic [W-1:0] rst_val_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// Reset to the idle level is a constant per bit, fed from a tie-off
			always_ff @(posedge ref_clk_in) begin
				if (!nrst_in) begin
					meta_r[i] <= rst_val_in[i];
					sync_out[i] <= rst_val_in[i];
				end else begin
					meta_r[i] <= async_in[i];
					sync_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* logic/byte_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_shifter (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Serial side
	input wire logic clear_in,
	input wire logic rise_in,
	input wire logic fall_in,
	input wire logic sdi_in,
	// Byte side
	input wire logic load_in,
	input wire logic [7:0] load_byte_in,
	output logic [7:0] rx_byte_out,
	output logic done_out,
	output logic [2:0] bit_cnt_out,
	output logic sdo_out
);
	logic [7:0] rx_r;
	logic [7:0] tx_r;

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || clear_in) begin
			rx_r <= spi_port_pkg::BYTE_ZERO;
			rx_byte_out <= spi_port_pkg::BYTE_ZERO;
			bit_cnt_out <= 3'h0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (rise_in) begin
				rx_r <= {rx_r[6:0], sdi_in};
				bit_cnt_out <= bit_cnt_out + 3'h1;
				if (bit_cnt_out == spi_port_pkg::LAST_BIT) begin
					// Eight rising edges per byte: at most one RAM access per byte
					rx_byte_out <= {rx_r[6:0], sdi_in};
					done_out <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || clear_in) begin
			tx_r <= spi_port_pkg::BYTE_ZERO;
			sdo_out <= 1'b0;
		end else if (load_in) begin
			tx_r <= load_byte_in;
			sdo_out <= load_byte_in[7];
		end else if (fall_in && bit_cnt_out != 3'h0) begin
			sdo_out <= tx_r[3'h7 - bit_cnt_out];
		end
	end
endmodule
`default_nettype wire

/* sim/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Serial link to the port
	output var logic sel_n_out,
	output var logic sck_out,
	output var logic sdi_out,
	input wire logic sdo_in
);
	// 400 ns bit period keeps the link only just below the port's limit
	localparam time HALF = 200ns;

	initial begin
		sel_n_out = 1'b1;
		sck_out = 1'b0;
		sdi_out = 1'b0;
	end

	// Clock idles low between frames; tail adds a partial final byte
	task automatic xfer(input logic [7:0] tx [$], input int tail, output logic [7:0] rx [$]);
		logic [7:0] sh;
		sh = 8'h00;
		rx = {};
		// Called on a system clock falling edge; every link edge stays on that grid
		sel_n_out = 1'b0;
		#(HALF);
		for (int i = 0; i <= tx.size(); i++) begin
			for (int b = 7; b >= 0; b--) begin
				if (i == tx.size() && b < 8 - tail) break;
				sdi_out = (i < tx.size()) ? tx[i][b] : 1'b1;
				#(HALF);
				sck_out = 1'b1;
				sh = {sh[6:0], sdo_in};
				#(HALF);
				sck_out = 1'b0;
			end
			if (i < tx.size()) rx.push_back(sh);
		end
		// Data line is left toggled so a stale level is never mistaken for data
		sdi_out = ~sdi_out;
		#(HALF);
		sel_n_out = 1'b1;
		#2us;
	endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic sel_n;
	logic sck;
	logic sdi;
	logic sdo;
	logic sdo_line;
	logic ram_hold = 1'b0;
	logic oe_n;
	logic pins;
	logic irq;
	logic [7:0] mpu_rdata;
	spi_port_pkg::mpu_bus_t mpu = '0;
	spi_port_pkg::ram_req_t ram;
	logic ram_ack = 1'b0;
	logic [7:0] ram_rdata = 8'h00;
	logic [7:0] mem [0:65535];
	logic [7:0] rx [$];
	logic [7:0] v;
	int errors = 0;
	int n_checks = 0;
	int irqs = 0;
	int i0;

	always #25 ref_clk_in = ~ref_clk_in;

	spi_slave_ram_port DUT (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.port_select_low_in(sel_n),
		.serial_clock_in(sck),
		.serial_in_pin_in(sdi),
		.serial_out_out(sdo),
		.serial_out_oe_n_out(oe_n),
		.pins_to_port_out(pins),
		.mpu_in(mpu),
		.mpu_rdata_out(mpu_rdata),
		.cmd_irq_out(irq),
		.ram_out(ram),
		.ram_ack_in(ram_ack),
		.ram_rdata_in(ram_rdata)
	);

	// Undriven line shows the inverse of the last bit, so a late enable is caught
	assign sdo_line = oe_n ? ~sdo : sdo;

	spi_host_model host (
		.sel_n_out(sel_n),
		.sck_out(sck),
		.sdi_out(sdi),
		.sdo_in(sdo_line)
	);

	always @(negedge ref_clk_in) begin
		if (irq === 1'b1) irqs++;
	end

	// RAM answers one cycle after each request while ram_hold is low
	always @(negedge ref_clk_in) begin
		ram_ack <= ram.req & ~ram_ack & ~ram_hold;
		ram_rdata <= mem[ram.addr];
		if (ram.req & ~ram_ack & ram.we) mem[ram.addr] <= ram.wdata;
	end

	task automatic mpu_rd(input logic sfr, input logic [15:0] a, output logic [7:0] d);
		@(negedge ref_clk_in);
		mpu.sfr = sfr;
		mpu.addr = a;
		mpu.rd = 1'b1;
		@(negedge ref_clk_in);
		mpu.rd = 1'b0;
		@(negedge ref_clk_in);
		d = mpu_rdata;
	endtask

	task automatic mpu_wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		mpu.sfr = 1'b0;
		mpu.addr = a;
		mpu.wdata = d;
		mpu.wr = 1'b1;
		@(negedge ref_clk_in);
		mpu.wr = 1'b0;
		repeat (2) @(negedge ref_clk_in);
	endtask

	task automatic chk_regs(input logic [7:0] cmd, input logic [7:0] st);
		logic [7:0] d;
		mpu_rd(1'b1, {8'h00, spi_port_pkg::CMD_SFR_ADDR}, d);
		`CHK("command reg", cmd, d)
		mpu_rd(1'b0, spi_port_pkg::STAT_ADDR, d);
		`CHK("status reg", st, d)
	endtask

	task automatic run(input logic [7:0] tx [$], input int tail);
		i0 = irqs;
		host.xfer(tx, tail, rx);
		`CHK("oe_n idle", 1'b1, oe_n)
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#1ms;
		errors++;
		final_report();
	end

	initial begin
		mem[16'h0200] = 8'h13;
		mem[16'h0201] = 8'h22;
		mem[16'h0202] = 8'h81;
		mem[16'h0203] = 8'h00;
		repeat (20) @(negedge ref_clk_in);
		nrst_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		`CHK("pins after reset", 1'b1, pins)
		`CHK("oe_n after reset", 1'b1, oe_n)
		mpu_rd(1'b0, spi_port_pkg::CFG_ADDR, v);
		`CHK("enable reg", 8'h10, v)
		chk_regs(8'h00, 8'h00);
		$display("test reset done");

		run('{8'h01, 8'h00, 8'h05, 8'h00, 8'hA5, 8'h3C}, 0);
		`CHK("status byte", 8'h00, rx[3])
		`CHK("write 0", 8'hA5, mem[16'h0100])
		`CHK("write 1", 8'h3C, mem[16'h0101])
		`CHK("irq write", i0 + 1, irqs)
		chk_regs(8'h05, 8'h28);
		$display("test write done");

		run('{8'h02, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
		`CHK("status byte", 8'h28, rx[3])
		`CHK("read 0", 8'h13, rx[4])
		`CHK("read 1", 8'h22, rx[5])
		`CHK("read 2", 8'h81, rx[6])
		`CHK("irq silent read", i0, irqs)
		chk_regs(8'h05, 8'h4C);
		$display("test read done");

		run('{8'h80}, 0);
		`CHK("irq single", i0 + 1, irqs)
		chk_regs(8'h80, 8'h3C);
		$display("test single done");

		run('{8'h03, 8'h00, 8'h00, 8'h00, 8'h5A}, 0);
		`CHK("status byte", 8'h3C, rx[3])
		`CHK("write silent", 8'h5A, mem[16'h0300])
		`CHK("irq silent write", i0, irqs)
		chk_regs(8'h80, 8'h04);
		$display("test silent write done");

		mpu_wr(spi_port_pkg::CFG_ADDR, 8'h00);
		`CHK("pins released", 1'b0, pins)
		run('{8'h42}, 0);
		`CHK("irq disabled", i0, irqs)
		chk_regs(8'h80, 8'h04);
		mpu_wr(spi_port_pkg::CFG_ADDR, 8'h10);
		`CHK("pins back", 1'b1, pins)
		$display("test disable done");

		run('{8'h03, 8'h10, 8'h07}, 4);
		mpu_rd(1'b0, spi_port_pkg::STAT_ADDR, v);
		`CHK("partial byte error", 1'b1, v[7])
		$display("test partial done");

		run('{8'h04, 8'h00}, 0);
		`CHK("irq two byte", i0, irqs)
		chk_regs(8'h07, 8'h3C);
		$display("test two byte done");

		// RAM never answers: the prefetch and every later access miss
		ram_hold = 1'b1;
		run('{8'h02, 8'h00, 8'h81, 8'h00, 8'h00}, 0);
		ram_hold = 1'b0;
		`CHK("status byte", 8'h3C, rx[3])
		`CHK("irq busy read", i0 + 1, irqs)
		chk_regs(8'h81, 8'hA4);
		$display("test not ready done");
		final_report();
	end
endmodule
`default_nettype wire
